// ===== logic/aperture_irq_pkg.sv
// aperture_irq_pkg: offsets, field positions, reset values and windows
// assumes the host reaches registers through an index port and a data port
`default_nettype none

package aperture_irq_pkg;
  // host i/o ports
  localparam logic [15:0] SEQ_INDEX_PORT  = 16'h03C4;
  localparam logic [15:0] SEQ_DATA_PORT   = 16'h03C5;
  // register indexes
  localparam logic [7:0]  IDX_MEM_MODE    = 8'h18;
  localparam logic [7:0]  IDX_IRQ_EN_MASK = 8'h19;
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h1A;
  localparam logic [7:0]  IDX_PIN_STATUS  = 8'h1C;
  localparam logic [7:0]  IDX_PIN_CTRL    = 8'h1F;
  // values after reset
  localparam logic [7:0]  RST_MEM_MODE    = 8'h00;
  localparam logic [7:0]  RST_IRQ_EN_MASK = 8'h00;
  localparam logic [7:0]  RST_STATUS      = 8'h00;
  localparam logic [7:0]  RST_INDEX       = 8'h00;
  // memory_mode_control fields
  localparam int          BIT_LINEAR      = 0;
  localparam int          BIT_ROTATION    = 1;
  localparam int          BIT_MEM_PATH    = 2;
  localparam int          GMODE_LO        = 3;
  localparam logic [1:0]  GMODE_STD       = 2'h0;
  localparam logic [1:0]  GMODE_PLANAR16  = 2'h1;
  // interrupt_enable_mask fields; bits 7 and 3 are reserved
  localparam int          IRQ_EN_LO       = 4;
  localparam logic [7:0]  IRQ_EN_WMASK    = 8'h77;
  // status positions
  localparam int          STAT_VGA_BIT    = 4;
  localparam int          PIN_EN_LO       = 4;
  // banked window select codes and bounds, inclusive
  localparam logic [1:0]  MAP_A0_BF       = 2'h0;
  localparam logic [1:0]  MAP_A0_AF       = 2'h1;
  localparam logic [1:0]  MAP_B0_B7       = 2'h2;
  localparam logic [31:0] WIN_A0_LO       = 32'h000A0000;
  localparam logic [31:0] WIN_AF_HI       = 32'h000AFFFF;
  localparam logic [31:0] WIN_B0_LO       = 32'h000B0000;
  localparam logic [31:0] WIN_B7_HI       = 32'h000B7000;
  localparam logic [31:0] WIN_B8_LO       = 32'h000B8000;
  localparam logic [31:0] WIN_BF_HI       = 32'h000BFFFF;
  // bank granule and linear aperture size in address bits
  localparam int          BANK_SHIFT      = 16;
  localparam int          LIN_APER_BITS   = 24;
endpackage

`default_nettype wire

// ===== logic/memory_aperture_and_irq_regs.sv
// memory_aperture_and_irq_regs: indexed memory-mode and interrupt registers
// assumes one clock; sources and pin control come from same-clock logic,
// user pins come straight from package pins
`timescale 1ns/1ps
`default_nettype none

module memory_aperture_and_irq_regs
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // host i/o port
  input  wire logic [15:0] host_addr_i,
  input  wire logic [7:0]  host_wdata_i,
  input  wire logic        host_wr_i,
  input  wire logic        host_rd_i,
  output logic      [7:0]  host_rdata_o,
  output logic             host_rvalid_o,
  // host memory decode
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [31:0] pci_bar_i,
  input  wire logic [1:0]  gc_mem_map_i,
  input  wire logic [7:0]  bank_select_i,
  input  wire logic        mapped_aperture_select_i,
  output logic             mem_hit_o,
  output logic      [23:0] mem_offset_o,
  output logic             low32_only_o,
  output logic             wrap_256k_o,
  output logic             rotation_blt_en_o,
  output logic             linear_mode_o,
  output logic             mmio_en_o,
  // interrupt sources
  input  wire logic        bus_master_irq_i,
  input  wire logic        zoom_video_irq_i,
  input  wire logic        draw_engine_irq_i,
  input  wire logic        vga_irq_i,
  input  wire logic [3:0]  user_pin_i,
  input  wire logic [7:0]  user_pin_ctrl_i,
  output logic             irq_o
);

  logic [7:0]  index_r;
  logic [7:0]  mem_mode_r;
  logic [7:0]  en_mask_r;
  logic [7:0]  status_r;
  logic [7:0]  pin_status_r;
  logic [7:0]  pin_ctrl_r;
  logic [3:0]  pin_meta_r;
  logic [3:0]  pin_sync_r;
  logic [7:0]  rd_mux;
  logic        wr_data;
  logic        wr_index;
  logic        rd_data;
  logic        win_hit;
  logic [31:0] win_base;
  logic        lin_hit;
  logic [23:0] bank_off;
  logic [2:0]  src_vec;

  // any enabled, unmasked and active bit across a group
  function automatic logic irq_any(input logic [3:0] en, input logic [3:0] mask,
                                   input logic [3:0] src);
    irq_any = |(en & ~mask & src);
  endfunction

  // i/o strobes
  assign wr_index = host_wr_i && (host_addr_i == aperture_irq_pkg::SEQ_INDEX_PORT);
  assign wr_data  = host_wr_i && (host_addr_i == aperture_irq_pkg::SEQ_DATA_PORT);
  assign rd_data  = host_rd_i && (host_addr_i == aperture_irq_pkg::SEQ_DATA_PORT);
  assign src_vec  = {bus_master_irq_i, zoom_video_irq_i, draw_engine_irq_i};

  // index latch
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      index_r <= aperture_irq_pkg::RST_INDEX;
    else if (wr_index)
      index_r <= host_wdata_i;
  end

  // memory_mode_control; cleared at reset
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      mem_mode_r <= aperture_irq_pkg::RST_MEM_MODE;
    else if (wr_data && index_r == aperture_irq_pkg::IDX_MEM_MODE)
      mem_mode_r <= host_wdata_i;
  end

  // interrupt_enable_mask; reserved bits always store zero
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      en_mask_r <= aperture_irq_pkg::RST_IRQ_EN_MASK;
    else if (wr_data && index_r == aperture_irq_pkg::IDX_IRQ_EN_MASK)
      en_mask_r <= host_wdata_i & aperture_irq_pkg::IRQ_EN_WMASK;
  end

  // user pins come from outside the clock domain: two flops before use
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end
    else
    begin
      pin_meta_r <= user_pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // pin control is loaded by the owning logic, never by the host port
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pin_ctrl_r <= aperture_irq_pkg::RST_STATUS;
    else
      pin_ctrl_r <= user_pin_ctrl_i;
  end

  // status registers follow the source levels; sources clear themselves,
  // so there is no sticky flag to lose against a clear
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      status_r     <= aperture_irq_pkg::RST_STATUS;
      pin_status_r <= aperture_irq_pkg::RST_STATUS;
    end
    else
    begin
      status_r     <= {3'h0, vga_irq_i, 1'b0, src_vec};
      pin_status_r <= {4'h0, pin_sync_r & pin_ctrl_r[7:4]};
    end
  end

  // read mux; unmapped indexes read zero
  always_comb
  begin
    case (index_r)
      aperture_irq_pkg::IDX_MEM_MODE:    rd_mux = mem_mode_r;
      aperture_irq_pkg::IDX_IRQ_EN_MASK: rd_mux = en_mask_r;
      aperture_irq_pkg::IDX_IRQ_STATUS:  rd_mux = status_r;
      aperture_irq_pkg::IDX_PIN_STATUS:  rd_mux = pin_status_r;
      aperture_irq_pkg::IDX_PIN_CTRL:    rd_mux = pin_ctrl_r;
      default:                           rd_mux = 8'h00;
    endcase
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      host_rdata_o  <= 8'h00;
      host_rvalid_o <= 1'b0;
    end
    else
    begin
      host_rvalid_o <= host_rd_i && (host_addr_i == aperture_irq_pkg::SEQ_INDEX_PORT || rd_data);
      if (rd_data)
        host_rdata_o <= rd_mux;
      else if (host_rd_i && host_addr_i == aperture_irq_pkg::SEQ_INDEX_PORT)
        host_rdata_o <= index_r;
    end
  end

  // banked window decode
  always_comb
  begin
    case (gc_mem_map_i)
      aperture_irq_pkg::MAP_A0_BF:
      begin
        win_base = aperture_irq_pkg::WIN_A0_LO;
        win_hit  = mem_addr_i >= aperture_irq_pkg::WIN_A0_LO && mem_addr_i <= aperture_irq_pkg::WIN_BF_HI;
      end
      aperture_irq_pkg::MAP_A0_AF:
      begin
        win_base = aperture_irq_pkg::WIN_A0_LO;
        win_hit  = mem_addr_i >= aperture_irq_pkg::WIN_A0_LO && mem_addr_i <= aperture_irq_pkg::WIN_AF_HI;
      end
      aperture_irq_pkg::MAP_B0_B7:
      begin
        win_base = aperture_irq_pkg::WIN_B0_LO;
        win_hit  = mem_addr_i >= aperture_irq_pkg::WIN_B0_LO && mem_addr_i <= aperture_irq_pkg::WIN_B7_HI;
      end
      default:
      begin
        win_base = aperture_irq_pkg::WIN_B8_LO;
        win_hit  = mem_addr_i >= aperture_irq_pkg::WIN_B8_LO && mem_addr_i <= aperture_irq_pkg::WIN_BF_HI;
      end
    endcase
  end

  // bank granule plus offset in window; linear aperture match on upper bits
  assign bank_off = 24'({bank_select_i, 16'h0000}) + 24'(mem_addr_i - win_base);
  assign lin_hit  = mem_addr_i[31:aperture_irq_pkg::LIN_APER_BITS]
                 == pci_bar_i[31:aperture_irq_pkg::LIN_APER_BITS];

  // registered memory decode; one cycle from address to hit
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mem_hit_o    <= 1'b0;
      mem_offset_o <= 24'h000000;
    end
    else if (mem_mode_r[aperture_irq_pkg::BIT_LINEAR])
    begin
      mem_hit_o    <= lin_hit;
      mem_offset_o <= mem_addr_i[23:0];
    end
    else
    begin
      mem_hit_o    <= win_hit;
      mem_offset_o <= bank_off;
    end
  end

  // datapath mode outputs; path bit lifts the 32-bit and wrap limits
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      low32_only_o      <= 1'b0;
      wrap_256k_o       <= 1'b0;
      rotation_blt_en_o <= 1'b0;
      linear_mode_o     <= 1'b0;
      mmio_en_o         <= 1'b0;
    end
    else
    begin
      low32_only_o      <= !mem_mode_r[aperture_irq_pkg::BIT_MEM_PATH]
                        && !mem_mode_r[aperture_irq_pkg::GMODE_LO + 1];
      wrap_256k_o       <= !mem_mode_r[aperture_irq_pkg::BIT_MEM_PATH]
                        && mem_mode_r[4:3] == aperture_irq_pkg::GMODE_STD;
      rotation_blt_en_o <= mem_mode_r[aperture_irq_pkg::BIT_ROTATION];
      linear_mode_o     <= mem_mode_r[aperture_irq_pkg::BIT_LINEAR];
      // linear on without mapped aperture still refuses register access
      mmio_en_o         <= mapped_aperture_select_i && mem_mode_r[aperture_irq_pkg::BIT_LINEAR];
    end
  end

  // combined interrupt request
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      irq_o <= 1'b0;
    else
      irq_o <= irq_any({1'b0, en_mask_r[6:4]}, {1'b0, en_mask_r[2:0]}, {1'b0, src_vec})
            || irq_any(pin_ctrl_r[7:4], pin_ctrl_r[3:0], pin_sync_r)
            || vga_irq_i;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence s_wr_sel(logic [7:0] idx);
    wr_data && index_r == idx;
  endsequence

  sequence s_read(logic [7:0] idx);
    rd_data && index_r == idx;
  endsequence

  // any write aimed at an index that the host may only read
  sequence s_ro_wr;
    wr_data && (index_r == aperture_irq_pkg::IDX_IRQ_STATUS
                || index_r == aperture_irq_pkg::IDX_PIN_STATUS
                || index_r == aperture_irq_pkg::IDX_PIN_CTRL);
  endsequence

  property p_mode_write;
    s_wr_sel(aperture_irq_pkg::IDX_MEM_MODE) |=> mem_mode_r == $past(host_wdata_i);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_read_back;
    s_read(aperture_irq_pkg::IDX_MEM_MODE) |=> host_rvalid_o && host_rdata_o == $past(mem_mode_r);
  endproperty
  a_read_back: assert property (p_read_back) else $error("read answer wrong");

  property p_std_low32;
    (mem_mode_r[4:2] == 3'h0) |=> low32_only_o && wrap_256k_o;
  endproperty
  a_std_low32: assert property (p_std_low32) else $error("standard mode limits missing");

  property p_path_full;
    (mem_mode_r[aperture_irq_pkg::BIT_MEM_PATH] && !mem_mode_r[4]) |=> !low32_only_o && !wrap_256k_o;
  endproperty
  a_path_full: assert property (p_path_full) else $error("path bit did not lift limits");

  property p_rotation;
    $rose(mem_mode_r[aperture_irq_pkg::BIT_ROTATION]) |-> ##1 rotation_blt_en_o;
  endproperty
  a_rotation: assert property (p_rotation) else $error("rotation enable not followed");

  property p_bank_b8;
    (!mem_mode_r[0] && gc_mem_map_i == 2'h3 && mem_addr_i == 32'h000B8000)
      |=> mem_hit_o && mem_offset_o == {$past(bank_select_i), 16'h0000};
  endproperty
  a_bank_b8: assert property (p_bank_b8) else $error("banked window decode wrong");

  property p_bank_miss;
    (!mem_mode_r[0] && gc_mem_map_i == 2'h1 && mem_addr_i == 32'h000B0000) |=> !mem_hit_o;
  endproperty
  a_bank_miss: assert property (p_bank_miss) else $error("window 01 too wide");

  property p_linear;
    (mem_mode_r[0] && mem_addr_i[31:24] == pci_bar_i[31:24]) |=> mem_hit_o;
  endproperty
  a_linear: assert property (p_linear) else $error("linear decode missed");

  property p_irq_unmasked;
    (en_mask_r[4] && !en_mask_r[0] && draw_engine_irq_i) |=> irq_o;
  endproperty
  a_irq_unmasked: assert property (p_irq_unmasked) else $error("enabled source gave no irq");

  property p_irq_masked;
    (src_vec != 3'h0 && (en_mask_r[6:4] & ~en_mask_r[2:0]) == 3'h0 && !vga_irq_i
      && (pin_ctrl_r[7:4] & ~pin_ctrl_r[3:0]) == 4'h0) |=> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked source raised irq");

  property p_reserved;
    en_mask_r[7] == 1'b0 && en_mask_r[3] == 1'b0 && pin_status_r[7:4] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_ro_write;
    s_ro_wr |=> $stable(mem_mode_r) && $stable(en_mask_r);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write took effect");

  property p_mmio_refused;
    !mapped_aperture_select_i |=> !mmio_en_o;
  endproperty
  a_mmio_refused: assert property (p_mmio_refused) else $error("mmio allowed without aperture");

endmodule

`default_nettype wire

// ===== test/host_port_model.sv
// host_port_model: host cpu side of the index/data i/o port
// assumes the device takes strobes on the rising clock edge
`timescale 1ns/1ps
`default_nettype none

module host_port_model
(
  // clock
  input  wire logic        clk_sys_i,
  // i/o port toward the device
  output logic      [15:0] host_addr_o,
  output logic      [7:0]  host_wdata_o,
  output logic             host_wr_o,
  output logic             host_rd_o,
  input  wire logic [7:0]  host_rdata_i,
  input  wire logic        host_rvalid_i
);
  // idle bus at time zero
  initial
  begin
    host_addr_o  = 16'h0000;
    host_wdata_o = 8'h00;
    host_wr_o    = 1'b0;
    host_rd_o    = 1'b0;
  end

  // one strobe cycle; released lines turn to garbage so stale values never help
  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_sys_i);
    host_addr_o  = a;
    host_wdata_o = d;
    host_wr_o    = w;
    host_rd_o    = !w;
    @(negedge clk_sys_i);
    host_wr_o    = 1'b0;
    host_rd_o    = 1'b0;
    host_addr_o  = ~a;
    host_wdata_o = ~d;
  endtask

  // select by index, then move the byte through the data port
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
    cyc(aperture_irq_pkg::SEQ_INDEX_PORT, idx, 1'b1);
    cyc(aperture_irq_pkg::SEQ_DATA_PORT, val, 1'b1);
  endtask

  // answer is taken one edge after the read strobe
  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] val, output logic ok);
    cyc(aperture_irq_pkg::SEQ_INDEX_PORT, idx, 1'b1);
    cyc(aperture_irq_pkg::SEQ_DATA_PORT, 8'h00, 1'b0);
    val = host_rdata_i;
    ok  = host_rvalid_i;
  endtask
endmodule

`default_nettype wire

// ===== test/memory_aperture_and_irq_regs_tb.sv
// memory_aperture_and_irq_regs_tb: register, decode and interrupt checks
// assumes host_port_model drives the i/o port; other inputs driven here
`timescale 1ns/1ps
`default_nettype none

module memory_aperture_and_irq_regs_tb;
  // clock, reset, port and device inputs
  logic        clk_sys_i  = 1'b0;
  logic        nrst_i     = 1'b0;
  logic [15:0] host_addr;
  logic [7:0]  host_wdata;
  logic        host_wr;
  logic        host_rd;
  logic [7:0]  host_rdata;
  logic        host_rvalid;
  logic [31:0] mem_addr   = 32'h0;
  logic [31:0] pci_bar    = 32'h0;
  logic [1:0]  gc_map     = 2'h0;
  logic [7:0]  bank       = 8'h0;
  logic        map_sel    = 1'b0;
  logic [2:0]  src        = 3'h0;
  logic        vga        = 1'b0;
  logic [3:0]  pins       = 4'h0;
  logic [7:0]  pin_ctrl   = 8'h00;
  // device outputs
  logic        mem_hit;
  logic [23:0] mem_off;
  logic        low32;
  logic        wrap;
  logic        rot;
  logic        lin;
  logic        mmio;
  logic        irq;
  int          err_total  = 0;
  int          n_compared = 0;
  // register indexes in order: mode, enable, status, pin status, pin control
  logic [7:0]  idx_v [5]  = '{aperture_irq_pkg::IDX_MEM_MODE, aperture_irq_pkg::IDX_IRQ_EN_MASK,
                              aperture_irq_pkg::IDX_IRQ_STATUS, aperture_irq_pkg::IDX_PIN_STATUS,
                              aperture_irq_pkg::IDX_PIN_CTRL};
  // mode value and expected {low32, wrap}
  logic [7:0]  md_v [5]   = '{8'h00, 8'h08, 8'h04, 8'h10, 8'h03};
  logic [1:0]  md_e [5]   = '{2'h3, 2'h2, 2'h0, 2'h0, 2'h3};
  // window code, address and expected {hit, offset} with bank 2
  logic [1:0]  wc [8]     = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [31:0] wa [8]     = '{32'hA0010, 32'hC0000, 32'hAFFFF, 32'hB0000,
                              32'hB7000, 32'hB7001, 32'hB8000, 32'hB7FFF};
  logic [24:0] we [8]     = '{25'h1020010, 25'h0, 25'h102FFFF, 25'h0, 25'h1027000, 25'h0, 25'h1020000, 25'h0};

  always #25 clk_sys_i = ~clk_sys_i;

  host_port_model u_host_port_model
  (
    .clk_sys_i     (clk_sys_i),
    .host_addr_o   (host_addr),
    .host_wdata_o  (host_wdata),
    .host_wr_o     (host_wr),
    .host_rd_o     (host_rd),
    .host_rdata_i  (host_rdata),
    .host_rvalid_i (host_rvalid)
  );

  memory_aperture_and_irq_regs u_memory_aperture_and_irq_regs
  (
    .clk_sys_i                (clk_sys_i),
    .nrst_i                   (nrst_i),
    .host_addr_i              (host_addr),
    .host_wdata_i             (host_wdata),
    .host_wr_i                (host_wr),
    .host_rd_i                (host_rd),
    .host_rdata_o             (host_rdata),
    .host_rvalid_o            (host_rvalid),
    .mem_addr_i               (mem_addr),
    .pci_bar_i                (pci_bar),
    .gc_mem_map_i             (gc_map),
    .bank_select_i            (bank),
    .mapped_aperture_select_i (map_sel),
    .mem_hit_o                (mem_hit),
    .mem_offset_o             (mem_off),
    .low32_only_o             (low32),
    .wrap_256k_o              (wrap),
    .rotation_blt_en_o        (rot),
    .linear_mode_o            (lin),
    .mmio_en_o                (mmio),
    .bus_master_irq_i         (src[2]),
    .zoom_video_irq_i         (src[1]),
    .draw_engine_irq_i        (src[0]),
    .vga_irq_i                (vga),
    .user_pin_i               (pins),
    .user_pin_ctrl_i          (pin_ctrl),
    .irq_o                    (irq)
  );

  // shared compare, counts every call
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    logic       ok;
    u_host_port_model.rd_reg(idx, v, ok);
    chk("rvalid", {31'h0, ok}, 32'h1);
    chk($sformatf("reg %h", idx), {24'h0, v}, {24'h0, exp});
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    u_host_port_model.wr_reg(idx, d);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // main sequence; inputs change on the falling edge only
  initial
  begin
    repeat (4) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    waitc(2);
    for (int i = 0; i < 5; i++)
      rd_chk(idx_v[i], 8'h00);
    $display("test reset done");
    wr(idx_v[1], 8'hFF);
    rd_chk(idx_v[1], 8'h77);
    wr(idx_v[0], 8'hE2);
    rd_chk(idx_v[0], 8'hE2);
    pin_ctrl = 8'h5A;
    for (int i = 2; i < 5; i++)
      wr(idx_v[i], 8'hFF);
    wr(8'h1B, 8'hFF);
    rd_chk(idx_v[2], 8'h00);
    rd_chk(idx_v[3], 8'h00);
    rd_chk(idx_v[4], 8'h5A);
    rd_chk(8'h1B, 8'h00);
    rd_chk(idx_v[0], 8'hE2);
    rd_chk(idx_v[1], 8'h77);
    u_host_port_model.cyc(aperture_irq_pkg::SEQ_INDEX_PORT, 8'h00, 1'b0);
    chk("index rvalid", {31'h0, host_rvalid}, 32'h1);
    chk("index", {24'h0, host_rdata}, 32'h19);
    pin_ctrl = 8'h00;
    $display("test access done");
    for (int i = 0; i < 5; i++)
    begin
      wr(idx_v[0], md_v[i]);
      waitc(2);
      chk("low32", {31'h0, low32}, {31'h0, md_e[i][1]});
      chk("wrap", {31'h0, wrap}, {31'h0, md_e[i][0]});
      chk("rot", {31'h0, rot}, {31'h0, md_v[i][1]});
      chk("lin", {31'h0, lin}, {31'h0, md_v[i][0]});
    end
    chk("mmio", {31'h0, mmio}, 32'h0);
    $display("test mode done");
    bank = 8'h02;
    wr(idx_v[0], 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      gc_map   = wc[i];
      mem_addr = wa[i];
      waitc(2);
      chk("hit", {31'h0, mem_hit}, {31'h0, we[i][24]});
      if (we[i][24])
        chk("offset", {8'h0, mem_off}, {8'h0, we[i][23:0]});
    end
    map_sel = 1'b1;
    wr(idx_v[0], 8'h01);
    pci_bar  = 32'h12000000;
    mem_addr = 32'h12345678;
    waitc(2);
    chk("mmio", {31'h0, mmio}, 32'h1);
    chk("hit", {31'h0, mem_hit}, 32'h1);
    chk("offset", {8'h0, mem_off}, 32'h345678);
    mem_addr = 32'h13000000;
    waitc(2);
    chk("hit", {31'h0, mem_hit}, 32'h0);
    $display("test decode done");
    for (int s = 0; s < 3; s++)
    begin
      src = 3'(1 << s);
      wr(idx_v[1], 8'h00);
      waitc(2);
      chk("irq", {31'h0, irq}, 32'h0);
      rd_chk(idx_v[2], 8'(1 << s));
      wr(idx_v[1], 8'(8'h10 << s));
      waitc(2);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(idx_v[1], 8'(8'h10 << s) | 8'(1 << s));
      waitc(2);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(idx_v[1], 8'h70 ^ 8'(8'h10 << s));
      waitc(2);
      chk("irq", {31'h0, irq}, 32'h0);
    end
    src = 3'h0;
    vga = 1'b1;
    wr(idx_v[1], 8'h00);
    waitc(2);
    chk("irq", {31'h0, irq}, 32'h1);
    rd_chk(idx_v[2], 8'h10);
    vga = 1'b0;
    $display("test source irq done");
    for (int p = 0; p < 4; p++)
    begin
      pins     = 4'(1 << p);
      pin_ctrl = 8'h10 << p;
      waitc(4);
      chk("irq", {31'h0, irq}, 32'h1);
      rd_chk(idx_v[3], 8'(1 << p));
      pin_ctrl = pin_ctrl | 8'(1 << p);
      waitc(4);
      chk("irq", {31'h0, irq}, 32'h0);
      pin_ctrl = 8'hF0 ^ 8'(8'h10 << p);
      waitc(4);
      chk("irq", {31'h0, irq}, 32'h0);
      rd_chk(idx_v[3], 8'h00);
    end
    pins = 4'h0;
    $display("test user pins done");
    wr(idx_v[0], 8'hFF);
    wr(idx_v[1], 8'hFF);
    nrst_i = 1'b0;
    waitc(2);
    nrst_i = 1'b1;
    waitc(2);
    rd_chk(idx_v[0], 8'h00);
    rd_chk(idx_v[1], 8'h00);
    $display("test second reset done");
    wrap_up();
  end

  // hang guard: the sequence needs well under 3000 cycles
  initial
  begin
    #(50 * 3000);
    err_total++;
    wrap_up();
  end
endmodule

`default_nettype wire
